// ===== rtl/uart_pins_defines.vh
`ifndef UART_PINS_DEFINES_VH
`define UART_PINS_DEFINES_VH

// ----------------------------------------------------------------------------
// register indices (avalon byte address = index * 4)
// ----------------------------------------------------------------------------
`define REG_DATA 3'h0
`define REG_INT_MASK 3'h1
`define REG_INT_STATUS 3'h2
`define REG_LINE_STATUS 3'h3
`define REG_MODEM_CONTROL 3'h4
`define REG_MODEM_STATUS 3'h5
`define REG_DIVISOR 3'h6
`define REG_ENHANCED_FEATURE 3'h7

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CTRL_DTR 0
`define CTRL_RTS 1
`define CTRL_OUT1 2
`define CTRL_OUT2 3
`define STAT_CTS 4
`define STAT_DSR 5
`define STAT_CARRIER 7
`define FEAT_AUTO_RTS 6
`define FEAT_AUTO_CTS 7
`define LSR_RX_READY 0
`define LSR_TX_SPACE 5
`define LSR_TX_IDLE 6
`define INT_RX_DATA 0
`define INT_TX_EMPTY 1
`define INT_MODEM 2
`define INT_OVERRUN 3

// ----------------------------------------------------------------------------
// reset values and timing counts
// ----------------------------------------------------------------------------
`define RESET_BYTE 8'h00
`define DIVISOR_RESET 8'h01
`define TICKS_PER_BIT 4'hf
`define TICKS_HALF_BIT 4'h7

`endif

// ===== rtl/byte_fifo.v
`timescale 1ns/1ns
`default_nettype none

module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter ADDR_W = 4
) (
  input wire sys_clk,
  input wire rst_n,
  input wire push,
  input wire [WIDTH-1:0] wdata,
  input wire pop,
  output wire [WIDTH-1:0] rdata,
  output wire full,
  output wire empty
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [ADDR_W:0] wr_ptr_q;
  reg [ADDR_W:0] rd_ptr_q;

  assign empty = (wr_ptr_q == rd_ptr_q);
  assign full = (wr_ptr_q[ADDR_W-1:0] == rd_ptr_q[ADDR_W-1:0]) && (wr_ptr_q[ADDR_W] != rd_ptr_q[ADDR_W]);
  assign rdata = mem[rd_ptr_q[ADDR_W-1:0]];

  always @(posedge sys_clk) begin
    if (push && !full) begin
      mem[wr_ptr_q[ADDR_W-1:0]] <= wdata;
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_ptr_q <= {(ADDR_W+1){1'b0}};
      rd_ptr_q <= {(ADDR_W+1){1'b0}};
    end else begin
      if (push && !full) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop && !empty) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end

endmodule // byte_fifo

`default_nettype wire

// ===== rtl/uart_pins.v
`timescale 1ns/1ns
`default_nettype none
`include "uart_pins_defines.vh"

// Overview of operation
// - host read strobe low returns selected register contents on the data bus
// - host write strobe low loads data bus into addressed register
// - rx_ready_n low while receive data waits unread, high otherwise
// - tx_space_n low while a transmit location is free, high when full
// - baud output carries generator clock at sixteen times the data rate for divisors of 2 or more
// - receiver times its sampling from the separate sixteen-times receive clock
// - drive_disable_n low while the host reads, high otherwise
// - user outputs follow modem control bits 2 and 3
// - reset holds all registers and outputs in reset state
// - during reset serial transmit and receive are disabled
// - clear-to-send state readable in modem status bit 4
// - clear-to-send gates transmission only when enhanced feature bit 7 set
// - data-set-ready and carrier-detect are status only
// - modem control bit 0 set drives dtr_n low, clear or reset high
// - modem control bit 1 drives rts_n low; auto mode adds flow control
module uart_pins #(
  parameter DEPTH = 16,
  parameter ADDR_W = 4
) (
  input wire sys_clk,
  input wire rst_n,
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire read_strobe_n,
  input wire write_strobe_n,
  input wire [2:0] host_addr,
  input wire [7:0] host_data_in,
  output reg [7:0] host_data_out,
  output reg host_data_oe,
  output reg drive_disable_n,
  output reg rx_ready_n,
  output reg tx_space_n,
  output reg baud_out_n,
  input wire rx_clk16,
  input wire serial_in,
  output reg serial_out,
  input wire cts_n,
  input wire dsr_n,
  input wire carrier_detect_n,
  output reg dtr_n,
  output reg rts_n,
  output reg user_out1_n,
  output reg user_out2_n,
  output reg irq
);

  localparam S_IDLE = 4'b0001;
  localparam S_START = 4'b0010;
  localparam S_DATA = 4'b0100;
  localparam S_STOP = 4'b1000;

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  reg [17:0] pin_s1_q;
  reg [17:0] pin_s2_q;
  wire [17:0] pin_raw = {read_strobe_n, write_strobe_n, host_addr, host_data_in, rx_clk16,
                         serial_in, cts_n, dsr_n, carrier_detect_n};
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      pin_s1_q <= 18'h3f8ff;
      pin_s2_q <= 18'h3f8ff;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
    end
  end
  wire rd_s = pin_s2_q[17];
  wire wr_s = pin_s2_q[16];
  wire [2:0] haddr_s = pin_s2_q[15:13];
  wire [7:0] hdata_s = pin_s2_q[12:5];
  wire rclk_s = pin_s2_q[4];
  wire rx_s = pin_s2_q[3];
  wire cts_s = pin_s2_q[2];
  wire dsr_s = pin_s2_q[1];
  wire carrier_s = pin_s2_q[0];

  reg rd_prev_q;
  reg wr_prev_q;
  reg rclk_prev_q;
  reg [2:0] modem_prev_q;
  wire host_rd_go = rd_prev_q && !rd_s;
  wire host_wr_go = wr_prev_q && !wr_s;
  wire rx_tick = !rclk_prev_q && rclk_s;

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  reg [7:0] int_mask_q;
  reg [7:0] int_status_q;
  reg [7:0] modem_control_reg_q;
  reg [7:0] divisor_q;
  reg [7:0] enhanced_feature_reg_q;

  wire tx_full;
  wire tx_empty;
  wire [7:0] tx_rdata;
  wire rx_full;
  wire rx_empty;
  wire [7:0] rx_rdata;
  reg [3:0] tx_state_q;
  reg [3:0] rx_state_q;

  // one access per cycle; host strobes take precedence over avalon
  wire avs_req = (avs_read || avs_write) && avs_waitrequest;
  wire host_acc = host_rd_go || host_wr_go;
  wire avs_acc = avs_req && !host_acc;
  wire acc_rd = host_rd_go || (avs_acc && avs_read);
  wire acc_wr = host_wr_go || (avs_acc && avs_write);
  wire [2:0] acc_idx = host_acc ? haddr_s : avs_address[4:2];
  wire [7:0] acc_wdata = host_acc ? hdata_s : avs_writedata[7:0];

  function [7:0] reg_read;
    input [2:0] idx;
    begin
      case (idx)
        `REG_DATA: reg_read = rx_rdata;
        `REG_INT_MASK: reg_read = int_mask_q;
        `REG_INT_STATUS: reg_read = int_status_q;
        `REG_LINE_STATUS: reg_read = {1'b0, tx_empty && tx_state_q[0], !tx_full, 4'h0, !rx_empty};
        `REG_MODEM_CONTROL: reg_read = modem_control_reg_q;
        `REG_MODEM_STATUS: reg_read = {!carrier_s, 1'b0, !dsr_s, !cts_s, 4'h0};
        `REG_DIVISOR: reg_read = divisor_q;
        `REG_ENHANCED_FEATURE: reg_read = enhanced_feature_reg_q;
        default: reg_read = `RESET_BYTE;
      endcase
    end
  endfunction

  wire [7:0] acc_rdata = reg_read(acc_idx);
  wire rx_pop = acc_rd && (acc_idx == `REG_DATA);
  wire tx_push = acc_wr && (acc_idx == `REG_DATA);

  // --------------------------------------------------------------------------
  // bus answers and host data bus
  // --------------------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_prev_q <= 1'b1;
      wr_prev_q <= 1'b1;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      host_data_out <= `RESET_BYTE;
      host_data_oe <= 1'b0;
      drive_disable_n <= 1'b1;
    end else begin
      rd_prev_q <= rd_s;
      wr_prev_q <= wr_s;
      avs_waitrequest <= !avs_acc;
      if (avs_acc && avs_read) begin
        avs_readdata <= {24'h000000, acc_rdata};
      end
      if (host_rd_go) begin
        host_data_out <= acc_rdata;
      end
      host_data_oe <= !rd_s;
      drive_disable_n <= rd_s;
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      int_mask_q <= `RESET_BYTE;
      modem_control_reg_q <= `RESET_BYTE;
      divisor_q <= `DIVISOR_RESET;
      enhanced_feature_reg_q <= `RESET_BYTE;
    end else if (acc_wr) begin
      case (acc_idx)
        `REG_INT_MASK: int_mask_q <= acc_wdata;
        `REG_MODEM_CONTROL: modem_control_reg_q <= acc_wdata;
        `REG_DIVISOR: divisor_q <= acc_wdata;
        `REG_ENHANCED_FEATURE: enhanced_feature_reg_q <= acc_wdata;
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // fifos
  // --------------------------------------------------------------------------
  reg tx_pop_q;
  reg rx_push_q;
  reg [7:0] rx_shift_q;

  byte_fifo #(.WIDTH(8), .DEPTH(DEPTH), .ADDR_W(ADDR_W)) tx_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .push(tx_push),
    .wdata(acc_wdata),
    .pop(tx_pop_q),
    .rdata(tx_rdata),
    .full(tx_full),
    .empty(tx_empty)
  );

  byte_fifo #(.WIDTH(8), .DEPTH(DEPTH), .ADDR_W(ADDR_W)) rx_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .push(rx_push_q),
    .wdata(rx_shift_q),
    .pop(rx_pop),
    .rdata(rx_rdata),
    .full(rx_full),
    .empty(rx_empty)
  );

  // --------------------------------------------------------------------------
  // baud rate generator
  // --------------------------------------------------------------------------
  reg [7:0] baud_cnt_q;
  wire baud_tick = (baud_cnt_q == 8'h00);
  wire [7:0] div_top = (divisor_q == 8'h00) ? 8'h00 : divisor_q - 8'h01;
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      baud_cnt_q <= 8'h00;
      baud_out_n <= 1'b1;
    end else begin
      baud_cnt_q <= baud_tick ? div_top : baud_cnt_q - 8'h01;
      baud_out_n <= (baud_cnt_q > {1'b0, divisor_q[7:1]}) || baud_tick;
    end
  end

  // --------------------------------------------------------------------------
  // transmitter
  // --------------------------------------------------------------------------
  reg [3:0] tx_tick_q;
  reg [2:0] tx_bit_q;
  reg [7:0] tx_shift_q;
  wire cts_ok = !enhanced_feature_reg_q[`FEAT_AUTO_CTS] || !cts_s;
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      tx_state_q <= S_IDLE;
      tx_tick_q <= 4'h0;
      tx_bit_q <= 3'h0;
      tx_shift_q <= `RESET_BYTE;
      tx_pop_q <= 1'b0;
      serial_out <= 1'b1;
    end else begin
      tx_pop_q <= 1'b0;
      case (tx_state_q)
        S_IDLE: begin
          serial_out <= 1'b1;
          if (!tx_empty && cts_ok && baud_tick && !tx_pop_q) begin
            tx_shift_q <= tx_rdata;
            tx_pop_q <= 1'b1;
            tx_tick_q <= `TICKS_PER_BIT;
            serial_out <= 1'b0;
            tx_state_q <= S_START;
          end
        end
        S_START, S_DATA: begin
          if (baud_tick) begin
            tx_tick_q <= tx_tick_q - 4'h1;
            if (tx_tick_q == 4'h0) begin
              tx_tick_q <= `TICKS_PER_BIT;
              serial_out <= tx_shift_q[0];
              tx_shift_q <= {1'b0, tx_shift_q[7:1]};
              if (tx_state_q[1]) begin
                tx_bit_q <= 3'h0;
                tx_state_q <= S_DATA;
              end else if (tx_bit_q == 3'h7) begin
                serial_out <= 1'b1;
                tx_state_q <= S_STOP;
              end else begin
                tx_bit_q <= tx_bit_q + 3'h1;
              end
            end
          end
        end
        S_STOP: begin
          if (baud_tick) begin
            tx_tick_q <= tx_tick_q - 4'h1;
            if (tx_tick_q == 4'h0) begin
              tx_state_q <= S_IDLE;
            end
          end
        end
        default: tx_state_q <= S_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // receiver, paced by the external sixteen-times clock
  // --------------------------------------------------------------------------
  reg [3:0] rx_tick_q;
  reg [2:0] rx_bit_q;
  reg overrun_ev_q;
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      rclk_prev_q <= 1'b1;
      rx_state_q <= S_IDLE;
      rx_tick_q <= 4'h0;
      rx_bit_q <= 3'h0;
      rx_shift_q <= `RESET_BYTE;
      rx_push_q <= 1'b0;
      overrun_ev_q <= 1'b0;
    end else begin
      rclk_prev_q <= rclk_s;
      rx_push_q <= 1'b0;
      overrun_ev_q <= 1'b0;
      if (rx_tick) begin
        rx_tick_q <= rx_tick_q - 4'h1;
        case (rx_state_q)
          S_IDLE: begin
            if (!rx_s) begin
              rx_tick_q <= `TICKS_HALF_BIT;
              rx_state_q <= S_START;
            end
          end
          S_START: begin
            if (rx_tick_q == 4'h0) begin
              rx_tick_q <= `TICKS_PER_BIT;
              rx_bit_q <= 3'h0;
              rx_state_q <= rx_s ? S_IDLE : S_DATA;
            end
          end
          S_DATA: begin
            if (rx_tick_q == 4'h0) begin
              rx_tick_q <= `TICKS_PER_BIT;
              rx_shift_q <= {rx_s, rx_shift_q[7:1]};
              rx_bit_q <= rx_bit_q + 3'h1;
              if (rx_bit_q == 3'h7) begin
                rx_state_q <= S_STOP;
              end
            end
          end
          S_STOP: begin
            if (rx_tick_q == 4'h0) begin
              rx_push_q <= !rx_full;
              overrun_ev_q <= rx_full;
              rx_state_q <= S_IDLE;
            end
          end
          default: rx_state_q <= S_IDLE;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // interrupts and status pins
  // --------------------------------------------------------------------------
  reg tx_empty_prev_q;
  wire [7:0] int_events = {4'h0, overrun_ev_q, (modem_prev_q != {cts_s, dsr_s, carrier_s}),
                           tx_empty && !tx_empty_prev_q, rx_push_q};
  wire [7:0] int_clear = (acc_wr && (acc_idx == `REG_INT_STATUS)) ? acc_wdata : 8'h00;
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      modem_prev_q <= 3'h7;
      tx_empty_prev_q <= 1'b1;
      int_status_q <= `RESET_BYTE;
      irq <= 1'b0;
      rx_ready_n <= 1'b1;
      tx_space_n <= 1'b0;
      dtr_n <= 1'b1;
      rts_n <= 1'b1;
      user_out1_n <= 1'b1;
      user_out2_n <= 1'b1;
    end else begin
      modem_prev_q <= {cts_s, dsr_s, carrier_s};
      tx_empty_prev_q <= tx_empty;
      int_status_q <= (int_status_q & ~int_clear) | int_events;
      irq <= |(int_status_q & int_mask_q);
      rx_ready_n <= rx_empty;
      tx_space_n <= tx_full;
      dtr_n <= !modem_control_reg_q[`CTRL_DTR];
      rts_n <= !modem_control_reg_q[`CTRL_RTS] || (enhanced_feature_reg_q[`FEAT_AUTO_RTS] && rx_full);
      user_out1_n <= !modem_control_reg_q[`CTRL_OUT1];
      user_out2_n <= !modem_control_reg_q[`CTRL_OUT2];
    end
  end
  // every register above takes its reset value under !rst_n

endmodule // uart_pins

`default_nettype wire

// ===== tb/uart_pins_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module uart_pins_monitor (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic host_data_oe,
  input wire logic drive_disable_n,
  input wire logic rx_ready_n,
  input wire logic tx_space_n,
  input wire logic serial_out,
  input wire logic dtr_n,
  input wire logic rts_n,
  input wire logic user_out1_n,
  input wire logic user_out2_n,
  input wire logic irq
);
  default clocking cb @(posedge sys_clk); endclocking
  // ----
  // cycles since the last register write
  // ----
  logic [3:0] wr_age_q;
  always_ff @(posedge sys_clk) begin
    if (!rst_n || avs_write || !write_strobe_n) wr_age_q <= 4'h0;
    else if (wr_age_q != 4'hf) wr_age_q <= wr_age_q + 4'h1;
  end
  sequence read_held; (!read_strobe_n) [*5]; endsequence
  sequence idle_held; read_strobe_n [*5]; endsequence
  sequence req_open; (avs_read || avs_write) && avs_waitrequest && read_strobe_n && write_strobe_n; endsequence
  reset_state_a: assert property (!rst_n |=> serial_out && dtr_n && rts_n && !irq)
    else $error("outputs not in reset state");
  reset_pins_a: assert property (!rst_n |=> user_out1_n && user_out2_n && drive_disable_n && rx_ready_n)
    else $error("pins not in reset state");
  tx_quiet_a: assert property ($fell(rst_n) |=> serial_out [*3])
    else $error("transmit not idle in reset");
  drive_read_a: assert property (disable iff (!rst_n) read_held |-> !drive_disable_n && host_data_oe)
    else $error("read not signalled");
  drive_idle_a: assert property (disable iff (!rst_n) idle_held |-> drive_disable_n && !host_data_oe)
    else $error("drive disable without read");
  wait_pulse_a: assert property (disable iff (!rst_n) !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  wait_answer_a: assert property (disable iff (!rst_n) req_open |-> ##[1:8] !avs_waitrequest)
    else $error("request not answered");
  outs_cause_a: assert property (disable iff (!rst_n)
    $changed({dtr_n, user_out1_n, user_out2_n}) |-> wr_age_q < 4'hc)
    else $error("modem output moved without write");
  space_rise_a: assert property (disable iff (!rst_n) $rose(tx_space_n) |-> wr_age_q < 4'h4)
    else $error("transmit space flag rose without write");
endmodule // uart_pins_monitor
bind uart_pins uart_pins_monitor uart_pins_monitor_i (.sys_clk(sys_clk), .rst_n(rst_n), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .read_strobe_n(read_strobe_n),
  .write_strobe_n(write_strobe_n), .host_data_oe(host_data_oe), .drive_disable_n(drive_disable_n),
  .rx_ready_n(rx_ready_n), .tx_space_n(tx_space_n), .serial_out(serial_out), .dtr_n(dtr_n), .rts_n(rts_n),
  .user_out1_n(user_out1_n), .user_out2_n(user_out2_n), .irq(irq));
`default_nettype wire

// ===== tb/host_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_cpu_model (
  input wire logic sys_clk,
  input wire logic [7:0] host_data_out,
  input wire logic host_data_oe,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [2:0] host_addr,
  output logic [7:0] host_data_in
);
  initial begin
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    host_addr = 3'h0;
    host_data_in = 8'h00;
  end
  // ----
  // strobes held six cycles, then six idle
  // ----
  task automatic host_write(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    host_addr <= a;
    host_data_in <= d;
    write_strobe_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    write_strobe_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    host_data_in <= ~d;
  endtask
  task automatic host_read(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    host_addr <= a;
    read_strobe_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    d = host_data_oe ? host_data_out : ~host_data_out;
    read_strobe_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
  endtask
endmodule // host_cpu_model
`default_nettype wire

// ===== tb/uart_pins_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "uart_pins_defines.vh"
module uart_pins_test;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic cts_n = 1'b1;
  logic dsr_n = 1'b1;
  logic carrier_detect_n = 1'b1;
  wire [31:0] avs_readdata;
  wire [7:0] host_data_in, host_data_out;
  wire [2:0] host_addr;
  wire read_strobe_n, write_strobe_n, avs_waitrequest, host_data_oe, drive_disable_n, rx_ready_n;
  wire tx_space_n, baud_out_n, serial_out, dtr_n, rts_n, user_out1_n, user_out2_n, irq;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic [7:0] hd;
  int n_baud = 0;
  always #25 sys_clk = ~sys_clk;
  // receiver clocked from the baud output, serial looped back
  uart_pins #(.DEPTH(16), .ADDR_W(4)) uart_pins_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .host_addr(host_addr), .host_data_in(host_data_in),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe), .drive_disable_n(drive_disable_n),
    .rx_ready_n(rx_ready_n), .tx_space_n(tx_space_n), .baud_out_n(baud_out_n), .rx_clk16(baud_out_n),
    .serial_in(serial_out), .serial_out(serial_out), .cts_n(cts_n), .dsr_n(dsr_n),
    .carrier_detect_n(carrier_detect_n), .dtr_n(dtr_n), .rts_n(rts_n), .user_out1_n(user_out1_n),
    .user_out2_n(user_out2_n), .irq(irq));
  host_cpu_model host_cpu_model_i (.sys_clk(sys_clk), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .host_addr(host_addr), .host_data_in(host_data_in));
  // ----
  // bus tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic av_write(input logic [2:0] idx, input logic [7:0] d);
    @(posedge sys_clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, d};
    avs_write <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  task automatic av_read(input logic [2:0] idx, output logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= {idx, 2'b00};
    avs_read <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask
  task automatic reset_and_check();
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (12) @(posedge sys_clk);
    check({23'h0, serial_out, dtr_n, rts_n, user_out1_n, user_out2_n, irq, drive_disable_n, rx_ready_n,
      tx_space_n}, 32'h1f6);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic wait_rx();
    for (int i = 0; i < 3000 && rx_ready_n !== 1'b0; i++) @(posedge sys_clk);
  endtask
  // clock cycles between two rising edges of the baud output
  task automatic baud_period(output int n);
    logic last;
    int k;
    n = 0;
    k = 0;
    last = baud_out_n;
    while (k < 2 && n < 100) begin
      @(posedge sys_clk);
      if (k > 0) n++;
      if (baud_out_n === 1'b1 && last === 1'b0) k++;
      last = baud_out_n;
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d, failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  // ----
  // tests
  // ----
  initial begin
    reset_and_check();
    for (int b = 0; b < 4; b++) begin
      av_write(`REG_MODEM_CONTROL, 8'h01 << b);
      repeat (3) @(posedge sys_clk);
      check({28'h0, user_out2_n, user_out1_n, rts_n, dtr_n}, {28'h0, ~(4'h1 << b)});
    end
    for (int v = 0; v < 8; v++) begin
      {carrier_detect_n, dsr_n, cts_n} <= v[2:0];
      repeat (4) @(posedge sys_clk);
      av_read(`REG_MODEM_STATUS, rd);
      check(rd & 32'hb0, {24'h0, ~v[2], 1'b0, ~v[1], ~v[0], 4'h0});
    end
    host_cpu_model_i.host_write(`REG_MODEM_CONTROL, 8'h0c);
    check({30'h0, user_out2_n, user_out1_n}, 32'h0);
    host_cpu_model_i.host_read(`REG_MODEM_CONTROL, hd);
    check({24'h0, hd}, 32'h0c);
    av_write(`REG_MODEM_CONTROL, 8'h00);
    // data-set-ready asserted for the transfers below; it must not matter
    dsr_n <= 1'b0;
    av_write(`REG_DIVISOR, 8'h04);
    baud_period(n_baud);
    check(n_baud, 32'h4);
    av_write(`REG_INT_MASK, 8'h01);
    av_write(`REG_INT_STATUS, 8'hff);
    av_write(`REG_DATA, 8'ha5);
    wait_rx();
    repeat (2) @(posedge sys_clk);
    check({31'h0, irq}, 32'h1);
    av_read(`REG_DATA, rd);
    check(rd, 32'ha5);
    repeat (3) @(posedge sys_clk);
    check({31'h0, rx_ready_n}, 32'h1);
    av_write(`REG_INT_STATUS, 8'h01);
    repeat (3) @(posedge sys_clk);
    check({31'h0, irq}, 32'h0);
    // auto clear-to-send keeps characters queued while cts_n is high
    av_write(`REG_ENHANCED_FEATURE, 8'h80);
    for (int i = 1; i <= 16; i++) begin
      av_write(`REG_DATA, 8'h3c);
      repeat (2) @(posedge sys_clk);
      check({31'h0, tx_space_n}, {31'h0, i == 16});
    end
    av_read(`REG_LINE_STATUS, rd);
    check(rd, 32'h00);
    repeat (200) @(posedge sys_clk);
    check({31'h0, serial_out}, 32'h1);
    cts_n <= 1'b0;
    for (int i = 0; i < 100 && tx_space_n !== 1'b0; i++) @(posedge sys_clk);
    check({31'h0, tx_space_n}, 32'h0);
    wait_rx();
    av_read(`REG_DATA, rd);
    check(rd, 32'h3c);
    reset_and_check();
    av_read(`REG_MODEM_CONTROL, rd);
    check(rd, 32'h0);
    av_read(`REG_DIVISOR, rd);
    check(rd, 32'h1);
    end_of_test();
  end
endmodule // uart_pins_test
`default_nettype wire
